// ===== pin_far_end.sv
// Model of the circuitry on the four port pins.
// Assumes the bench never drives a pin the device drives.
`timescale 1ns/100ps
module pin_far_end (
   // Clock
   input wire logic       ref_clk,
   // Device drive
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   // Bench drive
   input wire logic [3:0] ext_en,
   input wire logic [3:0] ext_val,
   // Resolved levels
   output logic     [3:0] pin_in
);
   logic [3:0] float_q = 4'h0;
   // Floating lines toggle so a stale level cannot pass for a driven one
   always_ff @(posedge ref_clk) begin
      float_q <= ~float_q;
   end
   always_comb begin
      pin_in[3] = ext_en[3] ? ext_val[3] : float_q[3];
      for (int i = 0; i < 3; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : float_q[i];
      end
   end
endmodule : pin_far_end

// ===== pin_sync.sv
// Two-flop synchroniser for the four port pins.
// Assumes raw pin levels are asynchronous to ref_clk.
`timescale 1ns/100ps
module pin_sync (
   // Clock, reset and enable
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   // Pin levels
   pin_sync_if.sync  pins
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [port4_pkg::NPINS-1:0] meta;
      logic [port4_pkg::NPINS-1:0] stable;
   } sync_state_t;

   sync_state_t st_q;
   sync_state_t st_d;

   // The first stage feeds only the second one
   always_comb begin
      st_d        = st_q;
      st_d.meta   = pins.raw;
      st_d.stable = st_q.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_q <= '0;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   assign pins.level = st_q.stable;
endmodule : pin_sync

// ===== pin_sync_if.sv
// Carrier between the pin controller and its two-flop pin synchroniser.
// Assumes both ends share ref_clk.
`timescale 1ns/100ps
interface pin_sync_if;
   logic [port4_pkg::NPINS-1:0] raw;
   logic [port4_pkg::NPINS-1:0] level;

   modport ctrl (output raw, input level);
   modport sync (input raw, output level);
endinterface : pin_sync_if

// ===== port4_pin_control.sv
// Port four pin controller: data and direction registers, pin muxing
// between general-purpose use and serial channel / interrupt functions.
// Assumes a classic Wishbone master on ref_clk and a power controller
// giving a one-hot operating mode on the same clock.
`timescale 1ns/100ps

module port4_pin_control (
   // Clock, reset and enable
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Port pins
   input  wire logic [3:0]  pin_in,
   output logic      [2:0]  pin_out,
   output logic      [2:0]  pin_oe,
   // Serial channel side
   input  wire logic        serial_tx_line,
   input  wire logic        serial_clock_out,
   output logic             serial_rx_line,
   output logic             serial_clock_in,
   // Interrupt request to the interrupt controller
   output logic             ext_irq,
   // Power controller, one-hot
   input  wire logic [2:0]  op_mode
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [2:0] data;
      logic [2:0] dir;
      logic [6:0] cfg;
      logic [2:0] out;
      logic [2:0] oe;
      logic       ack;
      logic [7:0] rdat;
      logic       rx;
      logic       sclk_in;
      logic       irq;
   } ctrl_state_t;

   ctrl_state_t st_q;
   ctrl_state_t st_d;

   pin_sync_if  sync_bus ();

   // ==========================================================
   // Pin synchroniser
   assign sync_bus.raw = pin_in;

   pin_sync pin_sync_inst (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .pins    (sync_bus.sync)
   );

   // ==========================================================
   // Helpers
   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [7:0] ref_a);
      addr_hit = (a == ref_a);
   endfunction : addr_hit

   // Read view: latched data on outputs, pin level on inputs
   function automatic logic [7:0] data_view(input logic [2:0] d,
                                            input logic [2:0] dir,
                                            input logic [3:0] lvl);
      logic [7:0] v;
      v = port4_pkg::UPPER_ONES;
      for (int i = 0; i < port4_pkg::NBIDIR; i++) begin
         v[i] = dir[i] ? d[i] : lvl[i];
      end
      v[port4_pkg::PIN_IRQ] = lvl[port4_pkg::PIN_IRQ];
      data_view = v;
   endfunction : data_view

   // ==========================================================
   // Pin function decode
   logic [3:0] lvl;
   logic       te;
   logic       re;
   logic       txpin;
   logic       cke_lo;
   logic       cke_hi;
   logic       ckmode;
   logic       irqsel;
   logic       tx_own;
   logic       clk_out_own;
   logic [2:0] fn_oe;
   logic [2:0] fn_out;

   assign lvl    = sync_bus.level;
   assign te     = st_q.cfg[port4_pkg::CFG_TE];
   assign re     = st_q.cfg[port4_pkg::CFG_RE];
   assign txpin  = st_q.cfg[port4_pkg::CFG_TXPIN];
   assign cke_lo = st_q.cfg[port4_pkg::CFG_CKE_LO];
   assign cke_hi = st_q.cfg[port4_pkg::CFG_CKE_HI];
   assign ckmode = st_q.cfg[port4_pkg::CFG_CKMODE];
   assign irqsel = st_q.cfg[port4_pkg::CFG_IRQSEL];

   assign tx_own      = txpin & te;
   assign clk_out_own = ~cke_hi & (cke_lo | ckmode);

   always_comb begin
      fn_oe  = st_q.dir;
      fn_out = st_q.data;
      // Pin 0: serial clock input wins over everything
      if (cke_hi) begin
         fn_oe[port4_pkg::PIN_SCLK]  = 1'b0;
         fn_out[port4_pkg::PIN_SCLK] = 1'b0;
      end else if (clk_out_own) begin
         fn_oe[port4_pkg::PIN_SCLK]  = 1'b1;
         fn_out[port4_pkg::PIN_SCLK] = serial_clock_out;
      end
      // Pin 1: receive data input
      if (re) begin
         fn_oe[port4_pkg::PIN_RX]  = 1'b0;
         fn_out[port4_pkg::PIN_RX] = 1'b0;
      end
      // Pin 2: transmit data output
      if (tx_own) begin
         fn_oe[port4_pkg::PIN_TX]  = 1'b1;
         fn_out[port4_pkg::PIN_TX] = serial_tx_line;
      end
   end

   // ==========================================================
   // Bus decode
   logic req;
   logic wr;
   logic rd_hit;

   // Ack the cycle after the request; writes land on the same edge
   assign req    = wb_cyc_i & wb_stb_i & ~st_q.ack;
   assign wr     = req & wb_we_i & wb_sel_i[0];
   assign rd_hit = addr_hit(wb_adr_i, port4_pkg::ADDR_DATA)
                 | addr_hit(wb_adr_i, port4_pkg::ADDR_DIR)
                 | addr_hit(wb_adr_i, port4_pkg::ADDR_SERCFG)
                 | addr_hit(wb_adr_i, port4_pkg::ADDR_LEVEL);

   // ==========================================================
   // Next state
   always_comb begin
      st_d     = st_q;
      st_d.ack = req;

      // Register writes
      if (wr && addr_hit(wb_adr_i, port4_pkg::ADDR_DATA)) begin
         st_d.data = wb_dat_i[2:0];
      end
      if (wr && addr_hit(wb_adr_i, port4_pkg::ADDR_DIR)) begin
         st_d.dir = wb_dat_i[2:0];
      end
      if (wr && addr_hit(wb_adr_i, port4_pkg::ADDR_SERCFG)) begin
         st_d.cfg = wb_dat_i[6:0];
      end

      // Register reads; unmapped addresses read zero
      st_d.rdat = 8'h00;
      if (req && !wb_we_i && rd_hit) begin
         if (addr_hit(wb_adr_i, port4_pkg::ADDR_DATA)) begin
            st_d.rdat = data_view(st_q.data, st_q.dir, lvl);
         end else if (addr_hit(wb_adr_i, port4_pkg::ADDR_DIR)) begin
            st_d.rdat = port4_pkg::DIR_READ;
         end else if (addr_hit(wb_adr_i, port4_pkg::ADDR_SERCFG)) begin
            st_d.rdat = {1'b0, st_q.cfg};
         end else begin
            st_d.rdat = {4'h0, lvl};
         end
      end

      // Alternate-function inputs from the pins
      st_d.rx      = re & lvl[port4_pkg::PIN_RX];
      st_d.sclk_in = cke_hi & lvl[port4_pkg::PIN_SCLK];
      st_d.irq     = irqsel & lvl[port4_pkg::PIN_IRQ];

      // Pin drive follows the power mode; retain freezes the oe and out flops
      if (op_mode[port4_pkg::MODE_STANDBY]) begin
         st_d.oe  = port4_pkg::BIDIR_ZERO;
         st_d.out = port4_pkg::BIDIR_ZERO;
      end else if (op_mode[port4_pkg::MODE_RETAIN]) begin
         st_d.oe  = st_q.oe;
         st_d.out = st_q.out;
      end else if (op_mode[port4_pkg::MODE_RUN]) begin
         st_d.oe  = fn_oe;
         st_d.out = fn_out;
      end
   end

   // ==========================================================
   // Registers
   // Reset leaves every pin high impedance until a direction or serial config write takes effect in run mode
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_q      <= '0;
         st_q.data <= port4_pkg::DATA_RESET[2:0];
         st_q.dir  <= port4_pkg::DIR_RESET[2:0];
         st_q.cfg  <= port4_pkg::CFG_RESET;
         st_q.oe   <= port4_pkg::BIDIR_ZERO;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_ack_o        = st_q.ack;
   assign wb_dat_o        = {port4_pkg::PAD_ZERO, st_q.rdat};
   assign pin_out         = st_q.out;
   assign pin_oe          = st_q.oe;
   assign serial_rx_line  = st_q.rx;
   assign serial_clock_in = st_q.sclk_in;
   assign ext_irq         = st_q.irq;

endmodule : port4_pin_control

// ===== port4_pin_control_tb_top.sv
// Testbench for the port four pin controller.
// Assumes a Wishbone answer one cycle after the request is taken.
`timescale 1ns/100ps
module port4_pin_control_tb_top;
   logic        ref_clk = 1'b0;
   logic        reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        serial_tx_line, serial_clock_out, serial_rx_line, serial_clock_in, ext_irq;
   logic [7:0]  wb_adr_i, q;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [3:0]  pin_in, ext_en, ext_val;
   logic [2:0]  pin_out, pin_oe, op_mode;
   logic [7:0]  cks [6] = '{8'h00, 8'h08, 8'h20, 8'h10, 8'h30, 8'h18};
   logic [7:0]  ckoe [6] = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h00};
   int          n_mismatch = 0;
   int          comparisons = 0;

   always #25 ref_clk = ~ref_clk;

   port4_pin_control port4_pin_control_inst (.ref_clk(ref_clk), .reset(reset),
      .clk_en(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .serial_tx_line(serial_tx_line), .serial_clock_out(serial_clock_out),
      .serial_rx_line(serial_rx_line), .serial_clock_in(serial_clock_in),
      .ext_irq(ext_irq), .op_mode(op_mode));
   pin_far_end pin_far_end_inst (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // ==========================================================
   // Tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, d};
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   // ==========================================================
   // Tests
   initial begin
      tick(3000);
      n_mismatch++;
      stop_test();
   end
   initial begin
      reset = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, serial_tx_line, serial_clock_out} = 5'h00;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h00000000;
      op_mode = 3'h1;
      ext_en = 4'hf;
      ext_val = 4'ha;
      tick(4);
      reset <= 1'b0;
      tick(1);
      chk(8'(pin_oe), 8'h00);
      rd(port4_pkg::ADDR_DIR, 8'hff);
      rd(port4_pkg::ADDR_DATA, 8'hfa);
      ext_en <= 4'h8;
      wr(port4_pkg::ADDR_DIR, 8'h07);
      tick(2);
      chk(8'(pin_oe), 8'h07);
      rd(port4_pkg::ADDR_DIR, 8'hff);
      rd(port4_pkg::ADDR_DATA, 8'hf8);
      ext_val <= 4'h2;
      wr(port4_pkg::ADDR_DATA, 8'h0d);
      tick(3);
      rd(port4_pkg::ADDR_DATA, 8'hf5);
      chk(8'(pin_out), 8'h05);
      op_mode <= 3'h2;
      wr(port4_pkg::ADDR_DIR, 8'h00);
      tick(2);
      chk(8'(pin_oe), 8'h07);
      op_mode <= 3'h4;
      tick(2);
      chk(8'(pin_oe), 8'h00);
      op_mode <= 3'h1;
      wr(port4_pkg::ADDR_DIR, 8'h07);
      wr(port4_pkg::ADDR_SERCFG, 8'h01);
      tick(2);
      chk(8'({pin_oe[2], pin_out[2]}), 8'h03);
      wr(port4_pkg::ADDR_SERCFG, 8'h05);
      tick(2);
      chk(8'({pin_oe[2], pin_out[2]}), 8'h02);
      serial_tx_line <= 1'b1;
      tick(3);
      chk(8'({pin_oe[2], pin_out[2]}), 8'h03);
      wr(port4_pkg::ADDR_SERCFG, 8'h02);
      tick(2);
      ext_en <= 4'ha;
      tick(4);
      chk(8'({pin_oe[1], serial_rx_line}), 8'h01);
      wr(port4_pkg::ADDR_DIR, 8'h00);
      for (int i = 0; i < 6; i++) begin
         // Serial clock differs from latched data on some steps, so a wrong source shows
         serial_clock_out <= i[0];
         wr(port4_pkg::ADDR_SERCFG, cks[i]);
         tick(2);
         chk(8'({pin_oe[0], pin_out[0]}), ckoe[i]);
      end
      // Clock input owns pin 0 now; drive it from outside
      ext_en <= 4'hb;
      ext_val <= 4'h3;
      tick(4);
      chk(8'(serial_clock_in), 8'h01);
      ext_val <= 4'ha;
      wr(port4_pkg::ADDR_SERCFG, 8'h40);
      tick(4);
      chk(8'(ext_irq), 8'h01);
      rd(port4_pkg::ADDR_SERCFG, 8'h40);
      wr(port4_pkg::ADDR_SERCFG, 8'h00);
      tick(4);
      chk(8'(ext_irq), 8'h00);
      // Mid-run reset with pins driven; release the bench drive first
      ext_en <= 4'h8;
      wr(port4_pkg::ADDR_DIR, 8'h07);
      tick(2);
      reset <= 1'b1;
      tick(2);
      chk(8'(pin_oe), 8'h00);
      reset <= 1'b0;
      ext_en <= 4'hf;
      tick(3);
      chk(8'(pin_oe), 8'h00);
      rd(port4_pkg::ADDR_LEVEL, 8'h0a);
      rd(8'h10, 8'h00);
      stop_test();
   end
endmodule : port4_pin_control_tb_top

// ===== port4_pkg.sv
// Constants shared by the port four pin controller and its pin synchroniser.
// Assumes an 8-bit register view placed in the low byte of a 32-bit bus.
package port4_pkg;

   // ==========================================================
   // Register map, byte addresses
   localparam logic [7:0] ADDR_DATA   = 8'h00;
   localparam logic [7:0] ADDR_DIR    = 8'h04;
   localparam logic [7:0] ADDR_SERCFG = 8'h08;
   localparam logic [7:0] ADDR_LEVEL  = 8'h0c;

   // ==========================================================
   // Widths and reset values
   localparam int          NPINS      = 4;
   localparam int          NBIDIR     = 3;
   localparam logic [7:0]  DATA_RESET = 8'hf8;
   localparam logic [7:0]  DIR_RESET  = 8'hf8;
   localparam logic [7:0]  DIR_READ   = 8'hff;
   localparam logic [7:0]  UPPER_ONES = 8'hf0;
   localparam logic [2:0]  BIDIR_ZERO = 3'h0;
   localparam logic [6:0]  CFG_RESET  = 7'h00;
   localparam logic [23:0] PAD_ZERO   = 24'h000000;

   // ==========================================================
   // Bit positions
   localparam int PIN_SCLK = 0;
   localparam int PIN_RX   = 1;
   localparam int PIN_TX   = 2;
   localparam int PIN_IRQ  = 3;

   localparam int CFG_TE     = 0;
   localparam int CFG_RE     = 1;
   localparam int CFG_TXPIN  = 2;
   localparam int CFG_CKE_LO = 3;
   localparam int CFG_CKE_HI = 4;
   localparam int CFG_CKMODE = 5;
   localparam int CFG_IRQSEL = 6;

   // One-hot operating mode inputs
   localparam int MODE_RUN     = 0;
   localparam int MODE_RETAIN  = 1;
   localparam int MODE_STANDBY = 2;
   localparam int NMODES       = 3;

endpackage : port4_pkg

// ===== port4_sva.sv
// Checker for the port four pin controller, bound to its top module.
// Assumes clk_en stays high, so each path has its nominal latency.
`timescale 1ns/100ps
module port4_sva (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        reset,
   // Bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Pins and modes
   input wire logic [3:0]  pin_in,
   input wire logic [2:0]  pin_out,
   input wire logic [2:0]  pin_oe,
   input wire logic        serial_rx_line,
   input wire logic        ext_irq,
   input wire logic [2:0]  op_mode
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("bus answer late or long");
   property p_dir; wb_ack_o && !wb_we_i && wb_adr_i == port4_pkg::ADDR_DIR
      |-> wb_dat_o == 32'h000000ff; endproperty
   a_dir: assert property (p_dir) else $error("direction read not all ones");
   property p_data; wb_ack_o && !wb_we_i && wb_adr_i == port4_pkg::ADDR_DATA
      |-> wb_dat_o[31:4] == 28'h000000f; endproperty
   a_data: assert property (p_data) else $error("data upper bits wrong");
   // Reset itself is the cause here, so it must not disable the check
   property p_rst; disable iff (1'b0) reset |=> pin_oe == 3'h0; endproperty
   a_rst: assert property (p_rst) else $error("pins driven in reset");
   property p_stby; op_mode == 3'h4 |=> pin_oe == 3'h0; endproperty
   a_stby: assert property (p_stby) else $error("pins driven in standby");
   property p_hold; op_mode == 3'h2 |=> $stable(pin_oe) && $stable(pin_out); endproperty
   a_hold: assert property (p_hold) else $error("pins moved in retain");
   property p_irq; ext_irq |-> $past(pin_in[3], 3); endproperty
   a_irq: assert property (p_irq) else $error("irq without pin level");
   property p_rx; serial_rx_line |-> $past(pin_in[1], 3); endproperty
   a_rx: assert property (p_rx) else $error("rx without pin level");
endmodule : port4_sva

bind port4_pin_control port4_sva port4_sva_inst (.ref_clk(ref_clk), .reset(reset),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .serial_rx_line(serial_rx_line), .ext_irq(ext_irq), .op_mode(op_mode));
